// [rtl/acc_pkg.sv]
package acc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACQ = 3'b010,
    ST_TRIAL = 3'b100
  } acc_state_t;
  typedef struct packed {
    logic [5:0] div;
    logic [6:0] acq;
  } acc_timing_t;
endpackage

// [rtl/acc_regs.svh]
// Overview of operation
// - Reset gives eight acquisition clocks, divide by two.
// - Conversion lasts acquisition plus 19 converter clocks.
// - Temperature channel forces 16 clocks, divide 32.
// - Other channels use the programmed timing again.
// - Control fields program divider and acquisition.
// - Ready flag bit 0 and interrupt at end.
// - Reading the result clears the ready flag.
// - Busy output high for the whole conversion.
// - Busy reaches port pin only when enabled.
// - Result holds the latest 12-bit conversion.
// - Reset register access restores converter defaults.
// - Control at 0xffff0500, resets to 0x00000a00.
// - Control sets enable, input mode, trigger type.
// - Positive and negative inputs selected separately.
// - Gain and offset calibration registers exist.
// - Divider codes 000 to 101 give 1 to 32.
// - Acquisition codes 000 to 101 give 2 to 64.
// - Single software conversion resets type to 000.
// - Result in bits 27:16, sign copies above in differential mode, zeros otherwise.
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_CTRL_ADDR 32'hffff0500
`define ACC_STAT_ADDR 32'hffff0504
`define ACC_RES_ADDR 32'hffff0508
`define ACC_PSEL_ADDR 32'hffff050c
`define ACC_NSEL_ADDR 32'hffff0510
`define ACC_RST_ADDR 32'hffff0514
`define ACC_GAIN_ADDR 32'hffff0518
`define ACC_OFFS_ADDR 32'hffff051c
`define ACC_GPO_ADDR 32'hffff0520
`define ACC_CTRL_RST 16'h0a00
`define ACC_DIV_MSB 13
`define ACC_DIV_LSB 11
`define ACC_ACQ_MSB 10
`define ACC_ACQ_LSB 8
`define ACC_EN_BIT 7
`define ACC_PWR_BIT 5
`define ACC_MODE_MSB 4
`define ACC_MODE_LSB 3
`define ACC_TYPE_MSB 2
`define ACC_TYPE_LSB 0
`define ACC_MODE_DIFF 2'h1
`define ACC_TY_EXT 3'h0
`define ACC_TY_T1 3'h1
`define ACC_TY_T0 3'h2
`define ACC_TY_SINGLE 3'h3
`define ACC_TY_CONT 3'h4
`define ACC_TY_PLA 3'h5
`define ACC_TY_PWM 3'h6
`define ACC_MAX_CODE 3'h5
`define ACC_TRIAL_CLKS 7'h13
`define ACC_TEMP_CH 5'h0d
`define ACC_TEMP_DIV 6'h20
`define ACC_TEMP_ACQ 7'h10
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2
`endif

// [rtl/acc_top.sv]
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "acc_regs.svh"
module acc_top import acc_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Converter core and triggers
  input wire logic [11:0] sample_code,
  input wire logic convst_in,
  input wire logic timer1_trig,
  input wire logic timer0_trig,
  input wire logic pla_trig,
  input wire logic pwm_trig,
  // Status and selection outputs
  output logic conversion_busy_out,
  output logic port0_bit2_pin,
  output logic conv_irq,
  output logic [4:0] positive_input_select,
  output logic [4:0] negative_input_select
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] converter_control;
  logic [11:0] gain_calibration;
  logic [11:0] offset_calibration;
  logic gpio_output_control;
  logic result_ready_flag;
  logic [31:0] converter_result;
  acc_state_t state;
  acc_state_t next_state;
  acc_timing_t cur;
  acc_timing_t prog;
  acc_timing_t next_cur;
  logic [5:0] div_cnt;
  logic [6:0] tick_cnt;
  logic aw_got;
  logic w_got;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] rd_data;
  logic rd_hit;
  logic trig_sel;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire wr_fire = aw_got && w_got && !bvalid;
  wire rd_fire = arvalid && arready;
  wire [31:0] wa = {awaddr_q[31:2], 2'h0};
  wire [31:0] ra = {araddr[31:2], 2'h0};
  wire wr_ctrl = wr_fire && (wa == `ACC_CTRL_ADDR);
  wire wr_psel = wr_fire && (wa == `ACC_PSEL_ADDR);
  wire wr_nsel = wr_fire && (wa == `ACC_NSEL_ADDR);
  wire wr_gain = wr_fire && (wa == `ACC_GAIN_ADDR);
  wire wr_offs = wr_fire && (wa == `ACC_OFFS_ADDR);
  wire wr_gpo = wr_fire && (wa == `ACC_GPO_ADDR);
  wire wr_hit = wr_ctrl || wr_psel || wr_nsel || wr_gain || wr_offs || wr_gpo ||
                (wa == `ACC_STAT_ADDR) || (wa == `ACC_RES_ADDR) || (wa == `ACC_RST_ADDR);
  wire rd_res = rd_fire && (ra == `ACC_RES_ADDR);
  wire soft_rst = (wr_fire && (wa == `ACC_RST_ADDR)) || (rd_fire && (ra == `ACC_RST_ADDR));
  wire creset = !aresetn || soft_rst;
  wire [31:0] wmerged = merge({16'h0, converter_control}, wdata_q, wstrb_q);
  wire [31:0] wnew = merge(32'h0, wdata_q, wstrb_q);

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0;
    if (ra == `ACC_CTRL_ADDR) rd_data = {16'h0, converter_control};
    else if (ra == `ACC_STAT_ADDR) rd_data = {31'h0, result_ready_flag};
    else if (ra == `ACC_RES_ADDR) rd_data = converter_result;
    else if (ra == `ACC_PSEL_ADDR) rd_data = {27'h0, positive_input_select};
    else if (ra == `ACC_NSEL_ADDR) rd_data = {27'h0, negative_input_select};
    else if (ra == `ACC_GAIN_ADDR) rd_data = {20'h0, gain_calibration};
    else if (ra == `ACC_OFFS_ADDR) rd_data = {20'h0, offset_calibration};
    else if (ra == `ACC_GPO_ADDR) rd_data = {31'h0, gpio_output_control};
    else if (ra != `ACC_RST_ADDR) rd_hit = 1'b0;
  end

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_got <= 1'b1;
        awaddr_q <= awaddr;
      end else if (wr_fire) begin
        aw_got <= 1'b0;
      end else if (!aw_got && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_got <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (wr_fire) begin
        w_got <= 1'b0;
      end else if (!w_got && !bvalid) begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `ACC_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `ACC_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (rd_fire) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_data;
        rresp <= rd_hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else begin
        if (rready) begin
          rvalid <= 1'b0;
        end
        if (!rvalid) begin
          arready <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Conversion timing
  // ----------------------------------------
  wire [2:0] dcode = converter_control[`ACC_DIV_MSB:`ACC_DIV_LSB];
  wire [2:0] acode = converter_control[`ACC_ACQ_MSB:`ACC_ACQ_LSB];
  wire [2:0] ctype = converter_control[`ACC_TYPE_MSB:`ACC_TYPE_LSB];
  wire [2:0] dsel = (dcode > `ACC_MAX_CODE) ? `ACC_MAX_CODE : dcode;
  wire [2:0] asel = (acode > `ACC_MAX_CODE) ? `ACC_MAX_CODE : acode;
  assign prog = {6'h01 << dsel, 7'h02 << asel};
  wire temp_ch = positive_input_select == `ACC_TEMP_CH;
  assign next_cur = temp_ch ? {`ACC_TEMP_DIV, `ACC_TEMP_ACQ} : prog;
  wire tick = div_cnt == (cur.div - 6'h01);
  wire acq_end = (state == ST_ACQ) && tick && (tick_cnt == (cur.acq - 7'h01));
  wire done = (state == ST_TRIAL) && tick && (tick_cnt == (`ACC_TRIAL_CLKS - 7'h01));
  wire armed = converter_control[`ACC_EN_BIT] && converter_control[`ACC_PWR_BIT];
  wire go = armed && trig_sel && (state == ST_IDLE);
  wire sign = (converter_control[`ACC_MODE_MSB:`ACC_MODE_LSB] == `ACC_MODE_DIFF) &&
              sample_code[11];

  always_comb begin
    case (ctype)
      `ACC_TY_EXT: trig_sel = convst_in;
      `ACC_TY_T1: trig_sel = timer1_trig;
      `ACC_TY_T0: trig_sel = timer0_trig;
      `ACC_TY_SINGLE: trig_sel = 1'b1;
      `ACC_TY_CONT: trig_sel = 1'b1;
      `ACC_TY_PLA: trig_sel = pla_trig;
      `ACC_TY_PWM: trig_sel = pwm_trig;
      default: trig_sel = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (go) next_state = ST_ACQ;
      ST_ACQ: if (acq_end) next_state = ST_TRIAL;
      ST_TRIAL: if (done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (soft_rst) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (creset) begin
      state <= ST_IDLE;
      cur <= {6'h01, 7'h02};
      div_cnt <= 6'h0;
      tick_cnt <= 7'h0;
    end else begin
      state <= next_state;
      if (go) cur <= next_cur;
      div_cnt <= (state == ST_IDLE || tick) ? 6'h0 : div_cnt + 6'h01;
      if (state == ST_IDLE || acq_end || done) begin
        tick_cnt <= 7'h0;
      end else if (tick) begin
        tick_cnt <= tick_cnt + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // Converter registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (creset) begin
      converter_control <= `ACC_CTRL_RST;
      positive_input_select <= 5'h0;
      negative_input_select <= 5'h0;
      gain_calibration <= 12'h0;
      offset_calibration <= 12'h0;
      result_ready_flag <= 1'b0;
      converter_result <= 32'h0;
      conv_irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        converter_control <= wmerged[15:0];
      end else if (done && ctype == `ACC_TY_SINGLE) begin
        converter_control[`ACC_TYPE_MSB:`ACC_TYPE_LSB] <= `ACC_TY_EXT;
      end
      if (wr_psel) positive_input_select <= wnew[4:0];
      if (wr_nsel) negative_input_select <= wnew[4:0];
      if (wr_gain) gain_calibration <= wnew[11:0];
      if (wr_offs) offset_calibration <= wnew[11:0];
      if (done) begin
        result_ready_flag <= 1'b1;
      end else if (rd_res) begin
        result_ready_flag <= 1'b0;
      end
      if (done) converter_result <= {{4{sign}}, sample_code, 16'h0};
      conv_irq <= done;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_output_control <= 1'b0;
      conversion_busy_out <= 1'b0;
      port0_bit2_pin <= 1'b0;
    end else begin
      if (wr_gpo) gpio_output_control <= wnew[0];
      conversion_busy_out <= next_state != ST_IDLE;
      port0_bit2_pin <= (next_state != ST_IDLE) && gpio_output_control;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [11:0] cyc;
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_IDLE) cyc <= 12'h0;
    else cyc <= cyc + 12'h001;
  end

  sequence s_start;
    state == ST_IDLE && next_state == ST_ACQ;
  endsequence

  a_reset_defaults: assert property (@(posedge aclk) $rose(aresetn) |->
    converter_control == `ACC_CTRL_RST) else $error("control default wrong");
  a_conv_length: assert property (@(posedge aclk) disable iff (!aresetn) done |->
    cyc + 12'h001 == 12'(({5'h0, cur.acq} + 12'h013) * {6'h0, cur.div}))
    else $error("conversion length wrong");
  a_temp_force: assert property (@(posedge aclk) disable iff (!aresetn)
    s_start and temp_ch |=> cur.div == `ACC_TEMP_DIV && cur.acq == `ACC_TEMP_ACQ)
    else $error("temperature timing not forced");
  a_prog_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    s_start and !temp_ch |=> cur == $past(prog)) else $error("programmed timing not used");
  a_ready_set: assert property (@(posedge aclk) disable iff (!aresetn)
    done && !soft_rst |=> result_ready_flag && conv_irq) else $error("ready not set");
  a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_res && !done |=> !result_ready_flag) else $error("read did not clear ready");
  a_busy_span: assert property (@(posedge aclk) disable iff (!aresetn)
    s_start |=> conversion_busy_out throughout (state != ST_IDLE))
    else $error("busy low during conversion");
  a_busy_end: assert property (@(posedge aclk) disable iff (!aresetn)
    done |=> !conversion_busy_out) else $error("busy stuck after end");
  a_pin_route: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 port0_bit2_pin == (conversion_busy_out && $past(gpio_output_control)))
    else $error("pin routing wrong");
  a_result_layout: assert property (@(posedge aclk) disable iff (!aresetn)
    done && !soft_rst |=> converter_result[27:16] == $past(sample_code))
    else $error("result placement wrong");
  a_single_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    done && ctype == `ACC_TY_SINGLE && !wr_ctrl && !soft_rst |=> ctype == `ACC_TY_EXT)
    else $error("single type not cleared");
  a_soft_reset: assert property (@(posedge aclk) disable iff (!aresetn) soft_rst |=>
    converter_control == `ACC_CTRL_RST && !result_ready_flag && state == ST_IDLE)
    else $error("soft reset incomplete");

endmodule

// [verif/adc_conversion_control_tb_top.sv]
`timescale 1ns/1ns
`include "acc_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module adc_conversion_control_tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [11:0] sample_code = 12'h000;
  logic [4:0] trig = 5'h00, psel, nsel;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, busy, pin, irq;
  int bad_count = 0, tests_run = 0;
  always #4 aclk = ~aclk;
  acc_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sample_code(sample_code), .convst_in(trig[0]), .timer1_trig(trig[1]),
    .timer0_trig(trig[2]), .pla_trig(trig[3]), .pwm_trig(trig[4]),
    .conversion_busy_out(busy), .port0_bit2_pin(pin), .conv_irq(irq),
    .positive_input_select(psel), .negative_input_select(nsel));
  // ----------------------------------------
  // Bus and conversion helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic timeout();
    bad_count++;
    $display("ERROR t=%0t wait expired got %h exp %h", $time, 1'b0, 1'b1);
    end_of_test();
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        return;
      end
    end
    timeout();
  endtask
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(d, e)
  endtask
  // Waits for a conversion, measures its busy length and watches pin and interrupt.
  task automatic run_conv(input int exp_n, input logic gpio_on);
    int n;
    logic seen, pin_ok;
    n = 0;
    pin_ok = 1'b1;
    while (!busy) begin
      @(posedge aclk);
      n++;
      if (n > 100) timeout();
    end
    trig <= 5'h00;
    n = 1;
    @(posedge aclk);
    while (busy && n < 3000) begin
      if (n > 1 && pin !== gpio_on) pin_ok = 1'b0;
      n++;
      @(posedge aclk);
    end
    `CHK(n, exp_n)
    seen = irq;
    @(posedge aclk);
    seen = seen | irq;
    `CHK(seen, 1'b1)
    `CHK(pin_ok, 1'b1)
  endtask
  function automatic int exp_cyc(int dv, int aq, int tp);
    if (tp != 0) return (16 + 19) * 32;
    return ((2 << aq) + 19) * (1 << dv);
  endfunction
  function automatic logic [31:0] exp_res(logic [11:0] c, int md);
    return {(md == 1) ? {4{c[11]}} : 4'h0, c, 16'h0000};
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [1:0] r;
    logic [31:0] d, ctl;
    logic [11:0] cd;
    logic [2:0] tys [6];
    logic [4:0] tbit [6];
    int s, dv, aq, md, tp, n;
    tys = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    tbit = '{5'h01, 5'h02, 5'h04, 5'h00, 5'h08, 5'h10};
    s = $urandom(44865);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(`ACC_CTRL_ADDR, 32'h00000a00);
    chk_rd(`ACC_STAT_ADDR, 32'h00000000);
    rd(32'hffff0600, d, r);
    `CHK(r, 2'h2)
    wr(32'hffff0600, 32'h00000000);
    `CHK(bresp, 2'h2)
    wstrb <= 4'h1;
    wr(`ACC_CTRL_ADDR, 32'h000000a3);
    wstrb <= 4'hf;
    run_conv((8 + 19) * 2, 1'b0);
    $display("test reset_defaults done");
    for (int i = 0; i < 8; i++) begin
      dv = $urandom_range(5, 0);
      aq = $urandom_range(5, 0);
      md = $urandom_range(2, 0);
      tp = (i % 3 == 1);
      cd = 12'($urandom);
      ctl = 32'((dv << 11) | (aq << 8) | (md << 3)) | 32'h000000a3;
      sample_code <= cd;
      wr(`ACC_GPO_ADDR, 32'(i % 2));
      wr(`ACC_PSEL_ADDR, (tp != 0) ? 32'h0000000d : 32'h00000005);
      wr(`ACC_CTRL_ADDR, ctl);
      run_conv(exp_cyc(dv, aq, tp), 1'(i % 2));
      chk_rd(`ACC_STAT_ADDR, 32'h00000001);
      chk_rd(`ACC_CTRL_ADDR, ctl & 32'hfffffff8);
      chk_rd(`ACC_RES_ADDR, exp_res(cd, md));
      chk_rd(`ACC_STAT_ADDR, 32'h00000000);
      $display("test random_conversion %0d done", i);
    end
    wr(`ACC_GPO_ADDR, 32'h00000000);
    wr(`ACC_PSEL_ADDR, 32'h00000005);
    for (int k = 0; k < 6; k++) begin
      wr(`ACC_CTRL_ADDR, 32'h000000a0 | 32'(tys[k]));
      trig <= tbit[k];
      run_conv(21, 1'b0);
      wr(`ACC_CTRL_ADDR, 32'h00000a00);
      n = 0;
      while (busy && n < 100) begin
        @(posedge aclk);
        n++;
      end
      if (busy) timeout();
      rd(`ACC_RES_ADDR, d, r);
      `CHK(d, {4'h0, cd, 16'h0000})
      $display("test trigger_type %0d done", tys[k]);
    end
    cd = 12'($urandom);
    sample_code <= ~cd;
    wr(`ACC_CTRL_ADDR, 32'h000000a3);
    run_conv(21, 1'b0);
    sample_code <= cd;
    wr(`ACC_CTRL_ADDR, 32'h000000a3);
    run_conv(21, 1'b0);
    chk_rd(`ACC_STAT_ADDR, 32'h00000001);
    chk_rd(`ACC_RES_ADDR, {4'h0, cd, 16'h0000});
    $display("test overwrite done");
    wr(`ACC_GAIN_ADDR, 32'hffffffff);
    chk_rd(`ACC_GAIN_ADDR, 32'h00000fff);
    wr(`ACC_OFFS_ADDR, 32'h00000abc);
    chk_rd(`ACC_OFFS_ADDR, 32'h00000abc);
    wr(`ACC_NSEL_ADDR, 32'h00000003);
    `CHK(nsel, 5'h03)
    `CHK(psel, 5'h05)
    wr(`ACC_CTRL_ADDR, 32'h00001010);
    wr(`ACC_RST_ADDR, 32'h00000000);
    chk_rd(`ACC_CTRL_ADDR, 32'h00000a00);
    chk_rd(`ACC_GAIN_ADDR, 32'h00000000);
    `CHK(psel, 5'h00)
    $display("test soft_reset done");
    end_of_test();
  end
endmodule
